// ==== hdl/lcdcd_top.sv ====
`timescale 1ns/1ps
module lcdcd_top #(
  parameter int ROW_CYCLES_P = lcdcd_pkg::ROW_CYCLES,
  parameter int FIFO_DEPTH_P = lcdcd_pkg::FIFO_DEPTH
) (
  input  wire logic             i_mclk,
  input  wire logic             i_arst_n,
  input  wire logic             i_ce,
  input  wire logic             i_scl,
  input  wire logic             i_sda,
  input  wire logic             i_address_select_pin,
  input  wire logic [3:0]       i_subaddress_pins,
  input  wire logic             i_sync,
  output logic                  o_sda_o,
  output logic                  o_sda_oe,
  output logic      [39:0]      o_column_outputs,
  output logic      [4:0]       o_row_index,
  output lcdcd_pkg::lcdcd_cfg_t o_cfg,
  output lcdcd_pkg::lcdcd_ptr_t o_ptr
);
  import lcdcd_pkg::*;

  typedef enum {ST_IDLE, ST_RX, ST_PUSH, ST_ACKW, ST_ACK, ST_RLOAD, ST_RWAIT,
                ST_TX, ST_RACK, ST_IGNORE} lcdcd_state_t;
  typedef enum {PH_ADDR, PH_CMD, PH_DATA} lcdcd_phase_t;

  // ------------------------------------------------------------------
  // Helpers.
  // ------------------------------------------------------------------
  function automatic logic [7:0] ram_addr(logic [1:0] b, logic [5:0] c);
    ram_addr = ({6'h00, b} * COLS_PER_BANK) + {2'h0, c};
  endfunction

  // Next data location after one byte in the given access mode.
  function automatic lcdcd_ptr_t ptr_step(lcdcd_ptr_t p, logic [1:0] m);
    lcdcd_ptr_t n;
    logic       col_wrap;
    n        = p;
    col_wrap = 1'b0;
    case (m)
      MODE_HALF: begin
        n.bank[0] = ~p.bank[0];
        col_wrap  = p.bank[0];
      end
      MODE_FULL: col_wrap = 1'b1;
      default: begin
        n.bank   = p.bank + 2'h1;
        col_wrap = (p.bank == 2'h3);
      end
    endcase
    if (col_wrap) begin
      if (p.col >= COL_LAST) begin
        n.col = 6'h00;
        n.sub = p.sub + 4'h1;
      end else begin
        n.col = p.col + 6'h01;
      end
    end
    return n;
  endfunction

  // ------------------------------------------------------------------
  // Reset release and pin synchronisers.
  // ------------------------------------------------------------------
  logic       rst_meta_reg;
  logic       rst_n;
  logic [7:0] meta_reg;
  logic [7:0] pin_reg;
  logic       scl_d_reg;
  logic       sda_d_reg;
  logic       sync_d_reg;

  // Reset is asserted at once and released through two flip-flops.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // Every pin passes two flops; idle bus lines reset high.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg   <= 8'hc0;
      pin_reg    <= 8'hc0;
      scl_d_reg  <= 1'b1;
      sda_d_reg  <= 1'b1;
      sync_d_reg <= 1'b0;
    end else if (i_ce) begin
      meta_reg   <= {i_scl, i_sda, i_sync, i_address_select_pin, i_subaddress_pins};
      pin_reg    <= meta_reg;
      scl_d_reg  <= pin_reg[7];
      sda_d_reg  <= pin_reg[6];
      sync_d_reg <= pin_reg[5];
    end
  end

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl       = pin_reg[7];
  assign sda       = pin_reg[6];
  assign scl_rise  = scl && !scl_d_reg;
  assign scl_fall  = !scl && scl_d_reg;
  assign bus_start = scl && scl_d_reg && sda_d_reg && !sda;
  assign bus_stop  = scl && scl_d_reg && !sda_d_reg && sda;

  // ------------------------------------------------------------------
  // Bus protocol engine.
  // ------------------------------------------------------------------
  lcdcd_state_t state_reg;
  lcdcd_phase_t ph_reg;
  logic [2:0]   cnt_reg;
  logic [7:0]   sh_reg;
  logic         ack_reg;
  logic         rw_reg;
  logic         cont_reg;
  logic         nack_reg;
  logic         fifo_ready;
  logic [7:0]   rd_a;
  lcdcd_ptr_t   ptr_reg;
  lcdcd_cfg_t   cfg_reg;
  logic [7:0]   byte_w;
  logic         byte_done;
  logic         sub_match;
  logic         addr_match;

  assign byte_w     = {sh_reg[6:0], sda};
  assign byte_done  = (state_reg == ST_RX) && scl_rise && (cnt_reg == 3'h7);
  assign sub_match  = (ptr_reg.sub == pin_reg[3:0]);
  assign addr_match = (byte_w[7:1] == {SLAVE_ADDR_HI, pin_reg[4]});

  // Start and stop take priority over every state.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      ph_reg    <= PH_ADDR;
      cnt_reg   <= 3'h0;
      sh_reg    <= 8'h00;
      ack_reg   <= 1'b0;
      rw_reg    <= 1'b0;
      cont_reg  <= 1'b0;
      nack_reg  <= 1'b0;
      o_sda_oe  <= 1'b0;
    end else if (i_ce) begin
      if (bus_start) begin
        state_reg <= ST_RX;
        ph_reg    <= PH_ADDR;
        cnt_reg   <= 3'h0;
        o_sda_oe  <= 1'b0;
      end else if (bus_stop) begin
        state_reg <= ST_IDLE;
        o_sda_oe  <= 1'b0;
      end else begin
        unique case (state_reg)
          ST_IDLE, ST_IGNORE: o_sda_oe <= 1'b0;
          ST_RX: if (scl_rise) begin
            sh_reg  <= byte_w;
            cnt_reg <= cnt_reg + 3'h1;
            if (cnt_reg == 3'h7) begin
              unique case (ph_reg)
                PH_ADDR: begin
                  ack_reg   <= 1'b1;
                  rw_reg    <= byte_w[0];
                  state_reg <= addr_match ? ST_ACKW : ST_IGNORE;
                end
                PH_CMD: begin
                  ack_reg   <= 1'b1;
                  cont_reg  <= byte_w[CONT_BIT];
                  state_reg <= ST_ACKW;
                end
                PH_DATA: begin
                  ack_reg   <= sub_match;
                  state_reg <= sub_match ? ST_PUSH : ST_ACKW;
                end
              endcase
            end
          end
          ST_PUSH: if (fifo_ready) begin
            state_reg <= ST_ACKW;
          end
          ST_ACKW: if (scl_fall) begin
            o_sda_oe  <= ack_reg;
            state_reg <= ST_ACK;
          end
          ST_ACK: if (scl_fall) begin
            o_sda_oe  <= 1'b0;
            cnt_reg   <= 3'h0;
            state_reg <= ST_RX;
            if (ph_reg == PH_ADDR) begin
              ph_reg    <= PH_CMD;
              state_reg <= rw_reg ? ST_RLOAD : ST_RX;
            end else if (ph_reg == PH_CMD && !cont_reg) begin
              ph_reg <= PH_DATA;
            end
          end
          ST_RLOAD: state_reg <= ST_RWAIT;
          ST_RWAIT: begin
            sh_reg    <= rd_a;
            cnt_reg   <= 3'h0;
            o_sda_oe  <= sub_match && !rd_a[7];
            state_reg <= ST_TX;
          end
          ST_TX: if (scl_fall) begin
            if (cnt_reg == 3'h7) begin
              o_sda_oe  <= 1'b0;
              state_reg <= ST_RACK;
            end else begin
              sh_reg   <= {sh_reg[6:0], 1'b0};
              cnt_reg  <= cnt_reg + 3'h1;
              o_sda_oe <= sub_match && !sh_reg[6];
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              nack_reg <= sda;
            end
            if (scl_fall) begin
              state_reg <= nack_reg ? ST_IGNORE : ST_RLOAD;
            end
          end
        endcase
      end
    end
  end

  logic cmd_ev;
  logic data_ev;
  logic rd_ev;
  assign cmd_ev  = byte_done && (ph_reg == PH_CMD);
  assign data_ev = byte_done && (ph_reg == PH_DATA);
  assign rd_ev   = (state_reg == ST_TX) && scl_fall && (cnt_reg == 3'h7);

  // Command decoding of mode, status, start bank and access mode.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= CFG_RST;
    end else if (i_ce && cmd_ev) begin
      if (byte_w[6] && !byte_w[5]) begin
        cfg_reg.sys  <= byte_w[4];
        cfg_reg.stat <= byte_w[3:2];
        cfg_reg.mux  <= byte_w[1:0];
      end else if (byte_w[6:4] == 3'h7) begin
        if (byte_w[3:2] == START_BANK_OP) begin
          cfg_reg.start <= byte_w[1:0];
        end else begin
          cfg_reg.mode <= byte_w[3:2];
        end
      end
    end
  end

  // Data pointer and subaddress counter.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg <= PTR_RST;
    end else if (i_ce) begin
      if (cmd_ev) begin
        if (!byte_w[6]) begin
          ptr_reg.col <= byte_w[5:0];
        end else if (byte_w[6:4] == 3'h6) begin
          ptr_reg.sub <= byte_w[3:0];
        end else if (byte_w[6:4] == 3'h7 && byte_w[3:2] != START_BANK_OP) begin
          ptr_reg.bank <= byte_w[1:0];
        end
      end else if (data_ev || rd_ev) begin
        ptr_reg <= ptr_step(ptr_reg, cfg_reg.mode);
      end
    end
  end

  // Written bytes wait here for a free memory write slot.
  lcdcd_wr_t wr_reg;
  lcdcd_wr_t drain;
  logic      drain_valid;
  logic      load_reg;

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
    end else if (i_ce && data_ev) begin
      wr_reg <= '{bank: ptr_reg.bank, col: ptr_reg.col, data: byte_w};
    end
  end

  lcdcd_fifo #(
    .WIDTH ($bits(lcdcd_wr_t)),
    .DEPTH (FIFO_DEPTH_P)
  ) u_fifo (
    .i_clk       (i_mclk),
    .i_rst_n     (rst_n),
    .i_ce        (i_ce),
    .i_in_valid  (state_reg == ST_PUSH),
    .i_in_data   (wr_reg),
    .o_in_ready  (fifo_ready),
    .o_out_valid (drain_valid),
    .o_out_data  (drain),
    .i_out_ready (!load_reg)
  );

  // ------------------------------------------------------------------
  // Row scan.
  // ------------------------------------------------------------------
  logic [4:0]  row_reg;
  logic [15:0] tick_reg;
  logic [5:0]  lcol_reg;
  logic        cap_v_reg;
  logic [5:0]  cap_col_reg;
  logic [39:0] line_reg;
  logic [7:0]  rd_b;
  logic [4:0]  last_row;
  logic [1:0]  row_bank;
  logic        sync_rise;
  logic        row_bit;

  assign last_row  = 5'({cfg_reg.mux, 3'h7} - 5'h08);
  assign row_bank  = cfg_reg.start + row_reg[4:3];
  assign sync_rise = pin_reg[5] && !sync_d_reg;
  assign row_bit   = rd_b[row_reg[2:0]];

  // Row timing, realigned to row 0 on each sync pulse.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      row_reg  <= 5'h00;
      tick_reg <= 16'h0000;
      load_reg <= 1'b0;
      lcol_reg <= 6'h00;
    end else if (i_ce) begin
      if (sync_rise) begin
        row_reg  <= 5'h00;
        tick_reg <= 16'h0000;
        load_reg <= 1'b1;
        lcol_reg <= 6'h00;
      end else if (tick_reg == 16'(ROW_CYCLES_P - 1)) begin
        row_reg  <= (row_reg >= last_row) ? 5'h00 : row_reg + 5'h01;
        tick_reg <= 16'h0000;
        load_reg <= 1'b1;
        lcol_reg <= 6'h00;
      end else begin
        tick_reg <= tick_reg + 16'h0001;
        if (load_reg) begin
          load_reg <= (lcol_reg != COL_LAST);
          lcol_reg <= lcol_reg + 6'h01;
        end
      end
    end
  end

  // Gather one row bit per column, then drive the full line out.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      cap_v_reg        <= 1'b0;
      cap_col_reg      <= 6'h00;
      line_reg         <= '0;
      o_column_outputs <= '0;
      o_row_index      <= 5'h00;
    end else if (i_ce) begin
      cap_v_reg   <= load_reg;
      cap_col_reg <= lcol_reg;
      if (cap_v_reg) begin
        line_reg[cap_col_reg] <= row_bit;
        if (cap_col_reg == COL_LAST) begin
          o_row_index <= row_reg;
          case (cfg_reg.stat)
            STAT_NORMAL: o_column_outputs <= {row_bit, line_reg[38:0]};
            STAT_ALLON:  o_column_outputs <= '1;
            STAT_INV:    o_column_outputs <= ~{row_bit, line_reg[38:0]};
            default:     o_column_outputs <= '0;
          endcase
        end
      end
    end
  end

  lcdcd_ram #(
    .WORDS (RAM_WORDS),
    .AW    (RAM_AW)
  ) u_ram (
    .i_clk     (i_mclk),
    .i_ce      (i_ce),
    .i_we      (drain_valid && !load_reg),
    .i_waddr   (ram_addr(drain.bank, drain.col)),
    .i_wdata   (drain.data),
    .i_ra_addr (ram_addr(ptr_reg.bank, ptr_reg.col)),
    .o_ra_data (rd_a),
    .i_rb_addr (ram_addr(row_bank, lcol_reg)),
    .o_rb_data (rd_b)
  );

  // Status copies and the open-drain data level.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_sda_o <= 1'b0;
      o_cfg   <= CFG_RST;
      o_ptr   <= PTR_RST;
    end else if (i_ce) begin
      o_sda_o <= 1'b0;
      o_cfg   <= cfg_reg;
      o_ptr   <= ptr_reg;
    end
  end

endmodule // lcdcd_top

// ==== hdl/lcdcd_pkg.sv ====
package lcdcd_pkg;

  // ------------------------------------------------------------------
  // Bus addressing and memory shape.
  // ------------------------------------------------------------------
  localparam logic [5:0] SLAVE_ADDR_HI = 6'h1e;
  localparam int         RAM_WORDS     = 160;
  localparam int         RAM_AW        = 8;
  localparam logic [7:0] COLS_PER_BANK = 8'h28;
  localparam logic [5:0] COL_LAST      = 6'h27;
  localparam int         FIFO_DEPTH    = 32;
  localparam int         ROW_CYCLES    = 256;

  // ------------------------------------------------------------------
  // Command byte layout.
  // ------------------------------------------------------------------
  localparam int         CONT_BIT      = 7;
  localparam logic [1:0] START_BANK_OP = 2'h3;

  // ------------------------------------------------------------------
  // Field encodings.
  // ------------------------------------------------------------------
  localparam logic [1:0] STAT_BLANK  = 2'h0;
  localparam logic [1:0] STAT_NORMAL = 2'h1;
  localparam logic [1:0] STAT_ALLON  = 2'h2;
  localparam logic [1:0] STAT_INV    = 2'h3;
  localparam logic [1:0] MUX_32      = 2'h0;
  localparam logic [1:0] MODE_CHAR   = 2'h0;
  localparam logic [1:0] MODE_HALF   = 2'h1;
  localparam logic [1:0] MODE_FULL   = 2'h2;

  // ------------------------------------------------------------------
  // Carriers.
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] bank;
    logic [5:0] col;
    logic [7:0] data;
  } lcdcd_wr_t;

  typedef struct packed {
    logic [3:0] sub;
    logic [1:0] bank;
    logic [5:0] col;
  } lcdcd_ptr_t;

  typedef struct packed {
    logic       sys;
    logic [1:0] stat;
    logic [1:0] mux;
    logic [1:0] start;
    logic [1:0] mode;
  } lcdcd_cfg_t;

  // Power-on defaults: blank, 1:32, start bank 0, character mode.
  localparam lcdcd_cfg_t CFG_RST = '{sys: 1'b0, stat: STAT_BLANK, mux: MUX_32,
                                     start: 2'h0, mode: MODE_CHAR};
  localparam lcdcd_ptr_t PTR_RST = '{sub: 4'h0, bank: 2'h0, col: 6'h00};

endpackage

// ==== hdl/lcdcd_ram.sv ====
`timescale 1ns/1ps
module lcdcd_ram #(
  parameter int WORDS = 160,
  parameter int AW    = 8
) (
  input  wire logic          i_clk,
  input  wire logic          i_ce,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [7:0]    i_wdata,
  input  wire logic [AW-1:0] i_ra_addr,
  output logic      [7:0]    o_ra_data,
  input  wire logic [AW-1:0] i_rb_addr,
  output logic      [7:0]    o_rb_data
);

  logic [7:0] mem [WORDS];

  // One write port and two registered read ports.
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (i_we) begin
        mem[i_waddr] <= i_wdata;
      end
      o_ra_data <= mem[i_ra_addr];
      o_rb_data <= mem[i_rb_addr];
    end
  end

endmodule // lcdcd_ram

// ==== hdl/lcdcd_fifo.sv ====
`timescale 1ns/1ps
module lcdcd_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_reg;
  logic [AW:0]      rp_reg;

  // Pointers carry one extra wrap bit so full and empty differ.
  assign o_in_ready  = !((wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]));
  assign o_out_valid = (wp_reg != rp_reg);
  assign o_out_data  = mem[rp_reg[AW-1:0]];

  // Pointer update on accepted handshakes.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else if (i_ce) begin
      if (i_in_valid && o_in_ready) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (o_out_valid && i_out_ready) begin
        rp_reg <= rp_reg + 1'b1;
      end
    end
  end

  // Storage.
  always_ff @(posedge i_clk) begin
    if (i_ce && i_in_valid && o_in_ready) begin
      mem[wp_reg[AW-1:0]] <= i_in_data;
    end
  end

endmodule // lcdcd_fifo

// ==== verification/lcdcd_top_asserts.sv ====
`timescale 1ns/1ps
module lcdcd_top_asserts
  import lcdcd_pkg::*;
#(
  parameter int ROW_CYCLES_P = 256,
  parameter int FIFO_DEPTH_P = 32
) (
  input wire logic        i_mclk,
  input wire logic        i_arst_n,
  input wire logic        i_ce,
  input wire logic        i_scl,
  input wire logic        i_sda,
  input wire logic        i_address_select_pin,
  input wire logic [3:0]  i_subaddress_pins,
  input wire logic        i_sync,
  input wire logic        o_sda_o,
  input wire logic        o_sda_oe,
  input wire logic [39:0] o_column_outputs,
  input wire logic [4:0]  o_row_index,
  input wire lcdcd_cfg_t  o_cfg,
  input wire lcdcd_ptr_t  o_ptr
);
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);

  // ------------------------------------------------------------------
  // Bus pin checks.
  // ------------------------------------------------------------------
  // The pin may only pull low, and only changes while the clock is low.
  sda_low_a: assert property (o_sda_o == 1'b0)
    else $error("data output not low");
  oe_rise_a: assert property ($rose(o_sda_oe) |-> !i_scl)
    else $error("data driven while clock high");
  oe_hold_a: assert property ($past(i_scl) && i_scl |-> $stable(o_sda_oe))
    else $error("data drive changed in clock high");
  reset_dflt_a: assert property ($rose(i_arst_n) |->
    (o_cfg == CFG_RST && o_ptr == PTR_RST && !o_sda_oe) [*3])
    else $error("reset defaults wrong");

  // ------------------------------------------------------------------
  // Scan checks.
  // ------------------------------------------------------------------
  // Column values follow the status, and rows step one by one.
  blank_cols_a: assert property (o_cfg.stat == STAT_BLANK &&
    $changed(o_column_outputs) |-> o_column_outputs == 40'h0)
    else $error("blank columns not zero");
  allon_cols_a: assert property (o_cfg.stat == STAT_ALLON &&
    $changed(o_column_outputs) |-> o_column_outputs == 40'hff_ffff_ffff)
    else $error("all-on columns not set");
  row_step_a: assert property ($changed(o_row_index) |->
    o_row_index == 5'h00 || o_row_index == $past(o_row_index) + 5'h01)
    else $error("row index jumped");
  sync_row_a: assert property ($rose(i_sync) |-> ##[1:80] o_row_index == 5'h00)
    else $error("sync did not restart rows");
  row_hold_a: assert property ($changed(o_row_index) |=> $stable(o_row_index) [*8])
    else $error("row held too briefly");

  cover property ($rose(o_sda_oe));
  cover property (o_cfg.stat == STAT_INV && $changed(o_column_outputs));
  cover property ($changed(o_ptr.sub));
endmodule // lcdcd_top_asserts

bind lcdcd_top lcdcd_top_asserts #(
  .ROW_CYCLES_P(ROW_CYCLES_P),
  .FIFO_DEPTH_P(FIFO_DEPTH_P)
) u_asserts (
  .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_scl(i_scl),
  .i_sda(i_sda), .i_address_select_pin(i_address_select_pin),
  .i_subaddress_pins(i_subaddress_pins), .i_sync(i_sync),
  .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_column_outputs(o_column_outputs),
  .o_row_index(o_row_index), .o_cfg(o_cfg), .o_ptr(o_ptr)
);

// ==== verification/lcdcd_i2c_master.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Bus master model: open-drain data with pull-up, clock idles high.
// ------------------------------------------------------------------
module lcdcd_i2c_master (
  input  wire logic i_sda_oe,
  output logic      o_scl,
  output logic      o_sda
);
  localparam realtime Q = 31.25;
  logic low = 1'b0;

  // The line is high unless either party pulls it down.
  assign o_sda = !(low || i_sda_oe);
  initial o_scl = 1'b1;

  // One pulse: data set while low, sampled in mid high.
  task automatic bit_io(input logic b, output logic s);
    #Q low = !b;
    #Q o_scl = 1'b1;
    #Q s = o_sda;
    #Q o_scl = 1'b0;
  endtask
  task automatic start();
    #Q low = 1'b0;
    #Q o_scl = 1'b1;
    #Q low = 1'b1;
    #Q o_scl = 1'b0;
  endtask
  task automatic stop();
    #Q low = 1'b1;
    #Q o_scl = 1'b1;
    #Q low = 1'b0;
    #Q;
  endtask
  // Sends a byte, then reads the acknowledge.
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  // Reads a byte; acknowledges only when more bytes are wanted.
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!more, s);
  endtask
endmodule // lcdcd_i2c_master

// ==== verification/test_lcdcd_top.sv ====
`timescale 1ns/1ps
module test_lcdcd_top;
  import lcdcd_pkg::*;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic        sel = 1'b0;
  logic [3:0]  pins = 4'h0;
  logic        sync = 1'b0;
  logic        scl, sda, oe, sda_o, ack;
  logic [39:0] cols;
  logic [4:0]  row;
  logic [7:0]  rd;
  lcdcd_cfg_t  cfg;
  lcdcd_ptr_t  ptr;
  int          err_total = 0;
  int          total_checks = 0;

  initial forever #4 mclk = ~mclk;

  lcdcd_top #(.ROW_CYCLES_P(64)) dut (
    .i_mclk(mclk), .i_arst_n(arst_n), .i_ce(1'b1), .i_scl(scl), .i_sda(sda),
    .i_address_select_pin(sel), .i_subaddress_pins(pins), .i_sync(sync),
    .o_sda_o(sda_o), .o_sda_oe(oe), .o_column_outputs(cols),
    .o_row_index(row), .o_cfg(cfg), .o_ptr(ptr));
  lcdcd_i2c_master mst (.i_sda_oe(oe), .o_scl(scl), .o_sda(sda));

  // ------------------------------------------------------------------
  // Helpers.
  // ------------------------------------------------------------------
  task automatic chk(input string w, input logic [39:0] e, input logic [39:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", w, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] b, input logic e);
    mst.wbyte(b, ack);
    chk("ack", 40'(e), 40'(ack));
  endtask
  task automatic open(input logic rw);
    mst.start();
    wr({SLAVE_ADDR_HI, sel, rw}, 1'b1);
  endtask

  // ------------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------------
  task automatic t_reset();
    chk("cfg", 40'(CFG_RST), 40'(cfg));
    chk("ptr", 40'(PTR_RST), 40'(ptr));
    chk("oe", 40'h0, 40'(oe));
  endtask
  task automatic t_addr();
    for (int s = 0; s < 2; s++) begin
      tick(1);
      sel = s[0];
      tick(4);
      mst.start();
      wr({SLAVE_ADDR_HI, !sel, 1'b0}, 1'b0);
      wr(8'h80, 1'b0);
      open(1'b0);
      wr(8'hE0, 1'b1);
      mst.stop();
    end
    tick(1);
    sel = 1'b0;
  endtask
  task automatic t_modes();
    for (int i = 3; i >= 0; i--) begin
      open(1'b0);
      wr({4'b0100, i[1:0], i[1:0]}, 1'b1);
      mst.stop();
      tick(140);
      chk("stat", 40'(i), 40'(cfg.stat));
      chk("mux", 40'(i), 40'(cfg.mux));
      if (!i[0]) chk("cols", {40{i[1]}}, cols);
    end
  endtask
  task automatic t_write();
    logic [7:0] c [5] = '{8'hC5, 8'hFE, 8'hF9, 8'hEF, 8'h27};
    tick(1);
    pins = 4'hf;
    tick(4);
    open(1'b0);
    foreach (c[k]) wr(c[k], 1'b1);
    wr(8'hA5, 1'b1);
    wr(8'h5A, 1'b0);
    mst.stop();
    tick(4);
    chk("ptr", 40'({4'h0, 2'h1, 6'h01}), 40'(ptr));
    chk("cfg", 40'({1'b0, STAT_NORMAL, 2'h1, 2'h2, MODE_FULL}), 40'(cfg));
  endtask
  task automatic t_char();
    tick(1);
    pins = 4'h0;
    tick(4);
    open(1'b0);
    wr(8'hE0, 1'b1);
    wr(8'hF3, 1'b1);
    wr(8'h05, 1'b1);
    wr(8'hA5, 1'b1);
    wr(8'h3C, 1'b1);
    mst.stop();
    tick(4);
    chk("ptr", 40'({4'h0, 2'h1, 6'h06}), 40'(ptr));
    open(1'b0);
    wr(8'hF4, 1'b1);
    wr(8'h05, 1'b1);
    wr(8'h10, 1'b1);
    wr(8'h22, 1'b1);
    mst.stop();
    tick(4);
    chk("ptr", 40'({4'h0, 2'h0, 6'h06}), 40'(ptr));
  endtask
  task automatic t_read();
    open(1'b0);
    wr(8'hF3, 1'b1);
    wr(8'h05, 1'b1);
    mst.stop();
    open(1'b1);
    mst.rbyte(1'b1, rd);
    chk("rd", 40'(8'hA5), 40'(rd));
    mst.rbyte(1'b0, rd);
    chk("rd", 40'(8'h3C), 40'(rd));
    mst.stop();
    tick(4);
    chk("oe", 40'h0, 40'(oe));
    open(1'b0);
    wr(8'hE5, 1'b1);
    wr(8'h65, 1'b1);
    mst.stop();
    open(1'b1);
    mst.rbyte(1'b0, rd);
    chk("rd", 40'(8'hFF), 40'(rd));
    mst.stop();
  endtask
  task automatic t_scan();
    open(1'b0);
    wr(8'hFF, 1'b1);
    wr(8'h44, 1'b1);
    mst.stop();
    tick(100);
    sync = 1'b1;
    tick(2);
    sync = 1'b0;
    tick(58);
    chk("row", 40'h0, 40'(row));
    chk("col5", 40'h1, 40'(cols[5]));
    tick(64);
    chk("row", 40'h1, 40'(row));
    chk("col5", 40'h0, 40'(cols[5]));
  endtask

  // ------------------------------------------------------------------
  // Run control.
  // ------------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    #1 arst_n = 1'b1;
    tick(8);
    t_reset();
    t_addr();
    t_modes();
    t_write();
    t_char();
    t_read();
    t_scan();
    end_of_test();
  end
  // A hung handshake ends the run as a failure.
  initial begin
    #400us;
    err_total++;
    end_of_test();
  end
endmodule // test_lcdcd_top
